/* test/adcts_chk.sv */
// assertion checker on the converter control ports
// assumes one clock domain, synchronous active-low reset; bound below
`timescale 1ns/100ps
`include "adcts_regs.vh"
module adcts_chk (
    input wire aclk,
    input wire aresetn,
    input wire adc_active,
    input wire scan_start,
    input wire scan_done,
    input wire conv_done,
    input wire [`ADCTS_RES_W-1:0] conv_result,
    input wire low_power,
    input wire charge_unit_enable,
    input wire bandgap_enable,
    input wire [4:0] pos_select,
    input wire temp_sensor_select,
    input wire result_write,
    input wire [`ADCTS_RES_W-1:0] result_data
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_cu_gate: assert property (
        charge_unit_enable |-> $past(adc_active))
        else $error("charge unit on while converter idle");
    a_bg_gate: assert property (
        bandgap_enable |-> $past(adc_active))
        else $error("bandgap on while converter idle");
    a_lp_cause: assert property (
        $rose(low_power) |-> $past(scan_done))
        else $error("low power entered without a finished scan");
    a_lp_leave: assert property (
        scan_start && !scan_done |=> !low_power)
        else $error("low power kept after scan start");
    a_temp_route: assert property (
        temp_sensor_select == ($past(pos_select) == `ADCTS_POS_TEMP))
        else $error("temperature select does not follow code");
    a_store_cause: assert property (
        result_write |-> $past(conv_done))
        else $error("result stored without a conversion");
    a_store_data: assert property (
        result_write |-> result_data == $past(conv_result))
        else $error("stored value differs from conversion");
    a_ref_nobuf: assert property (
        result_write |-> $past(pos_select) < `ADCTS_POS_REF_LO)
        else $error("reference channel result stored");
endmodule

bind adcts_ctrl adcts_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .adc_active(adc_active),
    .scan_start(scan_start), .scan_done(scan_done), .conv_done(conv_done),
    .conv_result(conv_result), .low_power(low_power),
    .charge_unit_enable(charge_unit_enable),
    .bandgap_enable(bandgap_enable), .pos_select(pos_select),
    .temp_sensor_select(temp_sensor_select),
    .result_write(result_write), .result_data(result_data)
);

/* test/adcts_core_model.sv */
// converter core model: turns a bench kick into one-cycle event pulses
// assumes kick is driven right after a rising edge
`timescale 1ns/100ps
module adcts_core_model (
    input wire aclk,
    input wire kick,
    input wire [1:0] kind,
    input wire [11:0] value,
    output reg scan_start = 1'b0,
    output reg scan_done = 1'b0,
    output reg conv_done = 1'b0,
    output reg [11:0] conv_result = 12'h000
);
    always @(posedge aclk) begin
        conv_done <= kick && kind == 2'h0;
        scan_start <= kick && kind == 2'h1;
        scan_done <= kick && kind == 2'h2;
        // outside a conversion the bus alternates between the last value and its inverse
        conv_result <= (kick && kind == 2'h0) ? value : ~conv_result;
    end
endmodule

/* test/adcts_ctrl_tb.sv */
// self-checking bench for the converter control block
// assumes the core model and the checker are compiled alongside
`timescale 1ns/100ps
`include "adcts_regs.vh"
module adcts_ctrl_tb;
reg aclk = 1'b0, aresetn = 1'b0, act = 1'b0, spk = 1'b0, kick = 1'b0;
reg awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
reg [1:0] kind = 2'h0;
reg [11:0] val = 12'h000;
reg [7:0] awa = 8'h00, ara = 8'h00;
reg [31:0] wd = 32'h0000_0000;
wire awr, wrd, bv, arr, rv, sst, sdn, cdn, sen, lpw, cue, bge, tsel, rw;
wire irq, sb;
wire [2:0] neg;
wire [1:0] br, rrs;
wire [31:0] rdt;
wire [11:0] cres, rdat;
wire [4:0] pos;
integer n_mismatch = 0;
integer checked = 0;
localparam [1:0] OK = `ADCTS_RESP_OKAY;
localparam [1:0] ER = `ADCTS_RESP_SLVERR;

adcts_ctrl u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rrs), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .adc_active(act), .small_package(spk),
    .scan_start(sst), .scan_done(sdn), .conv_done(cdn),
    .conv_result(cres), .scan_enable(sen), .low_power(lpw),
    .charge_unit_enable(cue), .bandgap_enable(bge), .pos_select(pos),
    .neg_select(neg), .temp_sensor_select(tsel), .sample_b_active(sb),
    .result_write(rw), .result_data(rdat), .irq(irq)
);
adcts_core_model u_core (
    .aclk(aclk), .kick(kick), .kind(kind), .value(val),
    .scan_start(sst), .scan_done(sdn), .conv_done(cdn), .conv_result(cres)
);

always #2 aclk = ~aclk;

task report_and_stop;
    begin
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    end
endtask

task chk(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
    begin
        checked = checked + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0s expected %h seen %h", nm, e, g);
        end
    end
endtask

task cyc(input integer n);
    begin
        repeat (n) @(posedge aclk);
        #1;
    end
endtask

// bus tasks sample the handshake at the edge, before it updates
task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    integer n;
    begin
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            n = n + 1;
        end while (bv !== 1'b1 && n < 50);
        bre <= 1'b0;
        chk("bvalid", 1, bv);
        chk("bresp", {30'h0, er}, {30'h0, br});
    end
endtask

task rd(input [7:0] a, input [31:0] e, input [1:0] er);
    integer n;
    begin
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
            n = n + 1;
        end while (rv !== 1'b1 && n < 50);
        rre <= 1'b0;
        chk("rvalid", 1, rv);
        chk("rdata", e, rdt);
        chk("rresp", {30'h0, er}, {30'h0, rrs});
    end
endtask

// kind 0 conversion, 1 scan start, 2 scan done; ends with outputs settled
task ev(input [1:0] k, input [11:0] v);
    begin
        @(posedge aclk);
        kind <= k;
        val <= v;
        kick <= 1'b1;
        @(posedge aclk);
        kick <= 1'b0;
        cyc(1);
    end
endtask

task set_in(input a, input s);
    begin
        @(posedge aclk);
        act <= a;
        spk <= s;
        cyc(2);
    end
endtask

function exp_match(input integer m, input [11:0] r);
    reg inw;
    begin
        inw = r >= 12'h100 && r <= 12'h200;
        case (m)
            0: exp_match = r < 12'h100;
            1: exp_match = r > 12'h100;
            2: exp_match = inw;
            default: exp_match = !inw;
        endcase
    end
endfunction

task t_regs;
    begin
        rd(`ADCTS_OFF_SCR, 32'h0000_0000, OK);
        rd(`ADCTS_OFF_HI, 32'h0000_0FFF, OK);
        wr(`ADCTS_OFF_SCR, 32'h0000_FFFF, OK);
        rd(`ADCTS_OFF_SCR, 32'h0000_F30F, OK);
        rd(8'h20, 32'h0000_0000, ER);
        wr(`ADCTS_OFF_RES, 32'h0000_0123, ER);
    end
endtask

task t_power;
    begin
        set_in(1'b1, 1'b0);
        wr(`ADCTS_OFF_SCR, 32'h0000_B000, OK);
        cyc(2);
        chk("scan_en", 1, sen);
        chk("cu_en", 1, cue);
        chk("bg_en", 1, bge);
        ev(2, 12'h000);
        chk("lowpow", 0, lpw);
        set_in(1'b0, 1'b0);
        chk("cu_en", 0, cue);
        chk("bg_en", 0, bge);
        set_in(1'b1, 1'b0);
        wr(`ADCTS_OFF_SCR, 32'h0000_4000, OK);
        cyc(2);
        chk("scan_en", 0, sen);
        chk("cu_en", 0, cue);
        chk("bg_en", 0, bge);
        ev(2, 12'h000);
        chk("lowpow", 1, lpw);
        ev(1, 12'h000);
        chk("lowpow", 0, lpw);
    end
endtask

task t_cmp;
    integer m, i;
    reg [11:0] r;
    reg e;
    begin
        wr(`ADCTS_OFF_LO, 32'h0000_0100, OK);
        wr(`ADCTS_OFF_HI, 32'h0000_0200, OK);
        for (m = 0; m < 4; m = m + 1) begin
            wr(`ADCTS_OFF_SCR, 32'h0000_0004 + m, OK);
            for (i = 0; i < 4; i = i + 1) begin
                r = (i < 2) ? 12'h0FF + i : 12'h1FE + i;
                e = exp_match(m, r);
                ev(0, r);
                chk("store", e, rw);
                if (e) chk("data", r, rdat);
            end
        end
        wr(`ADCTS_OFF_SCR, 32'h0000_0000, OK);
        ev(0, 12'h300);
        chk("store", 1, rw);
        chk("data", 12'h300, rdat);
        wr(`ADCTS_OFF_SCR, 32'h0000_000C, OK);
        ev(0, 12'h050);
        chk("store", 0, rw);
    end
endtask

task t_irq;
    integer m, i;
    reg e;
    begin
        wr(`ADCTS_OFF_MSK, 32'h0000_0001, OK);
        for (m = 0; m < 4; m = m + 1) begin
            for (i = 0; i < 2; i = i + 1) begin
                wr(`ADCTS_OFF_STS, 32'h0000_0007, OK);
                wr(`ADCTS_OFF_SCR, 32'h0000_0008 | (m << 8), OK);
                ev(1, 12'h000);
                ev(0, i ? 12'h150 : 12'h050);
                chk("store", 0, rw);
                ev(2, 12'h000);
                e = m == 1 || (m > 1 && i == 0);
                chk("irq", e, irq);
            end
        end
        wr(`ADCTS_OFF_SCR, 32'h0000_0108, OK);
        ev(2, 12'h000);
        chk("irq", 1, irq);
        rd(`ADCTS_OFF_STS, 32'h0000_0001, OK);
        wr(`ADCTS_OFF_MSK, 32'h0000_0000, OK);
        cyc(1);
        chk("irq", 0, irq);
        wr(`ADCTS_OFF_STS, 32'h0000_0001, OK);
        rd(`ADCTS_OFF_STS, 32'h0000_0000, OK);
    end
endtask

// the bad-channel event is unmasked, so irq shows a refused code
task chan(input [15:0] c, input s, input e);
    begin
        set_in(1'b1, s);
        wr(`ADCTS_OFF_STS, 32'h0000_0007, OK);
        wr(`ADCTS_OFF_ICS, {16'h0000, c}, OK);
        ev(0, 12'h123);
        chk("badch", e, irq);
        chk("pos", c[4:0], pos);
        chk("neg", c[7:5], neg);
        chk("temp", c[4:0] == `ADCTS_POS_TEMP, tsel);
        if (!e) chk("store", c[4:0] < `ADCTS_POS_REF_LO, rw);
    end
endtask

task t_chan;
    reg [4:0] p1;
    begin
        wr(`ADCTS_OFF_SCR, 32'h0000_0000, OK);
        wr(`ADCTS_OFF_MSK, 32'h0000_0004, OK);
        chan(16'h000C, 1'b1, 1'b1);
        chan(16'h000C, 1'b0, 1'b0);
        chan(16'h0020, 1'b0, 1'b1);
        chan(16'h0040, 1'b0, 1'b0);
        chan(16'h000F, 1'b0, 1'b1);
        chan(16'h000E, 1'b0, 1'b0);
        chan(16'h000D, 1'b0, 1'b0);
        chan(16'h001B, 1'b0, 1'b0);
        chan(16'h001F, 1'b0, 1'b0);
        chan(16'h4302, 1'b0, 1'b0);
        wr(`ADCTS_OFF_CTL, 32'h0000_0001, OK);
        ev(0, 12'h011);
        p1 = pos;
        chk("phase", 1, sb);
        ev(0, 12'h022);
        chk("alt", 5'h01, p1 ^ pos);
        wr(`ADCTS_OFF_CTL, 32'h0000_0000, OK);
    end
endtask

initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    report_and_stop;
end

initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_power;
    t_cmp;
    t_irq;
    t_chan;
    report_and_stop;
end
endmodule

/* verilog/adcts_chsel.v */
// input select decoder: legality and buffer presence of a channel code
// assumes codes are the same for sample a and sample b fields
`timescale 1ns/100ps
`include "adcts_regs.vh"

module adcts_chsel (
    input wire [4:0] pos_sel,
    input wire [2:0] neg_sel,
    input wire small_package,
    output wire pos_ok,
    output wire neg_ok,
    output wire has_buffer,
    output wire temp_sel,
    output wire charge_sel
);

    wire ext_ok;
    wire ref_sel;

    // the three highest inputs are not bonded on the small package
    assign ext_ok = (pos_sel <= `ADCTS_POS_AN12) &&
        !(small_package && (pos_sel > `ADCTS_POS_AN9)); // [R18]
    assign temp_sel = pos_sel == `ADCTS_POS_TEMP; // [R15]
    assign charge_sel = pos_sel == `ADCTS_POS_CHARGE; // [R14]
    assign ref_sel = pos_sel >= `ADCTS_POS_REF_LO; // [R14]
    assign pos_ok = ext_ok || temp_sel || charge_sel || ref_sel; // [R14]
    // reference and supply channels own no result buffer
    assign has_buffer = pos_ok && !ref_sel; // [R17]
    assign neg_ok = (neg_sel == `ADCTS_NEG_REF) ||
        (neg_sel == `ADCTS_NEG_AN1); // [R13]

endmodule

/* verilog/adcts_cmp.v */
// threshold comparator: decides whether one conversion is a valid match
// assumes lo/hi are the buffer pair; a single threshold uses lo only
`timescale 1ns/100ps
`include "adcts_regs.vh"

module adcts_cmp (
    input wire [1:0] compare_mode,
    input wire [`ADCTS_RES_W-1:0] result,
    input wire [`ADCTS_RES_W-1:0] thr_lo,
    input wire [`ADCTS_RES_W-1:0] thr_hi,
    output reg match
);

    // window bounds are inclusive on both ends
    always @* begin
        case (compare_mode)
            `ADCTS_CM_LT: match = result < thr_lo; // [R12]
            `ADCTS_CM_GT: match = result > thr_lo; // [R11]
            `ADCTS_CM_IN: begin
                match = (result >= thr_lo) && (result <= thr_hi); // [R10]
            end
            `ADCTS_CM_OUT: begin
                match = (result < thr_lo) || (result > thr_hi); // [R9]
            end
            default: match = 1'b0;
        endcase
    end

endmodule

/* verilog/adcts_ctrl.v */
// converter scan, threshold compare and input select control, axi4-lite
// assumes the converter core gives one-cycle conv_done/scan pulses on aclk
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "adcts_regs.vh"

// Functional notes
// R1: scan enable bit set runs automatic scanning, clear disables it.
// R2: low-power bit set drops to low power after scan, else full power.
// R3: charge unit request enables charge unit while converter is active.
// R4: bandgap request powers bandgap reference while converter is active.
// R5: irq mode: never, sequence done, valid compare, or both together.
// R6: write mode 10 discards results but still raises match interrupts.
// R7: write mode 01 stores a result only when it matches.
// R8: write mode 00 stores every result; mode 11 is reserved.
// R9: compare mode 11 matches outside the buffer-pair window.
// R10: compare mode 10 matches inside the buffer-pair window.
// R11: compare mode 01 matches when result exceeds the buffer value.
// R12: compare mode 00 matches when result is below the buffer value.
// R13: negative select 000 is reference/ground, 010 is input 1, others unused.
// R14: positive select: inputs 0-12, charge unit 01110, refs 11011-11111.
// R15: code 01101 selects temperature sensor without charge channel enable.
// R16: sample a selects use the same codes as sample b selects.
// R17: reference and supply channels have no result buffer.
// R18: small package treats inputs 10, 11 and 12 as unimplemented.
// R19: sample a selects by default, sample b only with alternate sampling.
module adcts_ctrl (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire adc_active,
    input wire small_package,
    input wire scan_start,
    input wire scan_done,
    input wire conv_done,
    input wire [`ADCTS_RES_W-1:0] conv_result,
    output reg scan_enable,
    output reg low_power,
    output reg charge_unit_enable,
    output reg bandgap_enable,
    output reg [4:0] pos_select,
    output reg [2:0] neg_select,
    output reg temp_sensor_select,
    output reg sample_b_active,
    output reg result_write,
    output reg [`ADCTS_RES_W-1:0] result_data,
    output reg irq
);

    reg boot_reg;
    reg aw_full_reg;
    reg w_full_reg;
    reg [7:0] waddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    reg [15:0] scr_reg;
    reg [15:0] ics_reg;
    reg [2:0] sts_reg;
    reg [2:0] msk_reg;
    reg alt_reg;
    reg [`ADCTS_RES_W-1:0] lo_reg;
    reg [`ADCTS_RES_W-1:0] hi_reg;
    reg [`ADCTS_RES_W-1:0] res_reg;
    reg match_seen_reg;
    reg [2:0] sts_next;
    reg [2:0] ev_set;
    reg [2:0] w1c;
    reg [31:0] rd_mux;
    reg rd_ok;
    reg wr_ok;
    reg scan_irq;
    reg store;

    wire aw_hs;
    wire w_hs;
    wire ar_hs;
    wire do_write;
    wire [15:0] wr16;
    wire [15:0] wmask;
    wire [1:0] irq_mode;
    wire [1:0] wmode;
    wire use_b;
    wire [4:0] pos_cur;
    wire [2:0] neg_cur;
    wire pos_ok;
    wire neg_ok;
    wire has_buffer;
    wire temp_sel;
    wire match;
    wire match_ev;

    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wmask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    assign wr16 = wdata_reg[15:0];
    assign irq_mode = scr_reg[`ADCTS_IRQM_HI:`ADCTS_IRQM_LO];
    assign wmode = scr_reg[`ADCTS_WM_HI:`ADCTS_WM_LO];

    // alternate sampling swaps to sample b on every other conversion
    assign use_b = alt_reg && sample_b_active; // [R19]
    assign pos_cur = use_b ? ics_reg[12:8] : ics_reg[4:0]; // [R16]
    assign neg_cur = use_b ? ics_reg[15:13] : ics_reg[7:5]; // [R16]

    adcts_chsel u_chsel (
        .pos_sel(pos_select),
        .neg_sel(neg_select),
        .small_package(small_package),
        .pos_ok(pos_ok),
        .neg_ok(neg_ok),
        .has_buffer(has_buffer),
        .temp_sel(temp_sel),
        .charge_sel()
    );

    adcts_cmp u_cmp (
        .compare_mode(scr_reg[`ADCTS_CM_HI:`ADCTS_CM_LO]),
        .result(conv_result),
        .thr_lo(lo_reg),
        .thr_hi(hi_reg),
        .match(match)
    );

    assign match_ev = conv_done && match;

    // register read mux, unmapped words answer slverr with zero data
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `ADCTS_OFF_SCR: rd_mux[15:0] = scr_reg;
            `ADCTS_OFF_ICS: rd_mux[15:0] = ics_reg;
            `ADCTS_OFF_STS: rd_mux[2:0] = sts_reg;
            `ADCTS_OFF_MSK: rd_mux[2:0] = msk_reg;
            `ADCTS_OFF_CTL: rd_mux[0] = alt_reg;
            `ADCTS_OFF_LO: rd_mux[`ADCTS_RES_W-1:0] = lo_reg;
            `ADCTS_OFF_HI: rd_mux[`ADCTS_RES_W-1:0] = hi_reg;
            `ADCTS_OFF_RES: rd_mux[`ADCTS_RES_W-1:0] = res_reg;
            default: rd_ok = 1'b0;
        endcase
    end

    always @* begin
        case (waddr_reg)
            `ADCTS_OFF_SCR: wr_ok = 1'b1;
            `ADCTS_OFF_ICS: wr_ok = 1'b1;
            `ADCTS_OFF_STS: wr_ok = 1'b1;
            `ADCTS_OFF_MSK: wr_ok = 1'b1;
            `ADCTS_OFF_CTL: wr_ok = 1'b1;
            `ADCTS_OFF_LO: wr_ok = 1'b1;
            `ADCTS_OFF_HI: wr_ok = 1'b1;
            `ADCTS_OFF_RES: wr_ok = 1'b0;
            default: wr_ok = 1'b0;
        endcase
    end

    // storing decision per write mode; reserved mode 11 stores nothing
    always @* begin
        case (wmode)
            `ADCTS_WM_LEGACY: store = conv_done; // [R8]
            `ADCTS_WM_SAVE_MATCH: store = match_ev; // [R7]
            `ADCTS_WM_COMPARE: store = 1'b0; // [R6]
            default: store = 1'b0; // [R8]
        endcase
        // no buffer exists for reference and supply channels
        store = store && has_buffer; // [R17]
    end

    // interrupt condition per irq mode, independent of write mode
    always @* begin
        case (irq_mode)
            `ADCTS_IRQM_NONE: scan_irq = 1'b0; // [R5]
            `ADCTS_IRQM_SEQ: scan_irq = scan_done; // [R5]
            `ADCTS_IRQM_MATCH: scan_irq = match_ev; // [R5] [R6]
            `ADCTS_IRQM_BOTH: begin
                scan_irq = scan_done && (match_seen_reg || match_ev); // [R5]
            end
            default: scan_irq = 1'b0;
        endcase
    end

    // event bits: a set in the same cycle as a write-one-clear wins
    always @* begin
        ev_set = 3'b000;
        ev_set[`ADCTS_EV_SCAN] = scan_irq;
        ev_set[`ADCTS_EV_STORE] = store;
        ev_set[`ADCTS_EV_BADCH] = conv_done && !(pos_ok && neg_ok);
        w1c = 3'b000;
        if (do_write && waddr_reg == `ADCTS_OFF_STS && wstrb_reg[0]) begin
            w1c = wdata_reg[2:0];
        end
        sts_next = (sts_reg & ~w1c) | ev_set;
    end

    // axi4-lite write channel, address and data accepted in any order
    always @(posedge aclk) begin
        if (!aresetn) begin
            boot_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADCTS_RESP_OKAY;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            waddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            boot_reg <= 1'b1;
            if (!boot_reg) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (aw_hs) begin
                s_axi_awready <= 1'b0;
                aw_full_reg <= 1'b1;
                waddr_reg <= s_axi_awaddr;
            end
            if (w_hs) begin
                s_axi_wready <= 1'b0;
                w_full_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `ADCTS_RESP_OKAY : `ADCTS_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read channel: data is captured on the address handshake edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ADCTS_RESP_OKAY;
        end else begin
            if (!boot_reg) begin
                s_axi_arready <= 1'b1;
            end
            if (ar_hs) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? `ADCTS_RESP_OKAY : `ADCTS_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // software registers; unimplemented control bits are held at zero
    always @(posedge aclk) begin
        if (!aresetn) begin
            scr_reg <= `ADCTS_SCR_RST;
            ics_reg <= `ADCTS_ICS_RST;
            msk_reg <= 3'b000;
            alt_reg <= 1'b0;
            lo_reg <= `ADCTS_LO_RST;
            hi_reg <= `ADCTS_HI_RST;
        end else if (do_write) begin
            case (waddr_reg)
                `ADCTS_OFF_SCR: begin
                    scr_reg <= ((scr_reg & ~wmask) | (wr16 & wmask)) &
                        `ADCTS_SCR_MASK;
                end
                `ADCTS_OFF_ICS: begin
                    ics_reg <= (ics_reg & ~wmask) | (wr16 & wmask);
                end
                `ADCTS_OFF_MSK: begin
                    if (wstrb_reg[0]) begin
                        msk_reg <= wdata_reg[2:0];
                    end
                end
                `ADCTS_OFF_CTL: begin
                    if (wstrb_reg[0]) begin
                        alt_reg <= wdata_reg[0];
                    end
                end
                `ADCTS_OFF_LO: begin
                    lo_reg <= (lo_reg & ~wmask[`ADCTS_RES_W-1:0]) |
                        (wdata_reg[`ADCTS_RES_W-1:0] &
                        wmask[`ADCTS_RES_W-1:0]);
                end
                `ADCTS_OFF_HI: begin
                    hi_reg <= (hi_reg & ~wmask[`ADCTS_RES_W-1:0]) |
                        (wdata_reg[`ADCTS_RES_W-1:0] &
                        wmask[`ADCTS_RES_W-1:0]);
                end
                default: begin
                end
            endcase
        end
    end

    // converter-facing state, events and interrupt output
    always @(posedge aclk) begin
        if (!aresetn) begin
            sts_reg <= 3'b000;
            irq <= 1'b0;
            res_reg <= {`ADCTS_RES_W{1'b0}};
            match_seen_reg <= 1'b0;
            scan_enable <= 1'b0;
            low_power <= 1'b0;
            charge_unit_enable <= 1'b0;
            bandgap_enable <= 1'b0;
            pos_select <= 5'h00;
            neg_select <= 3'h0;
            temp_sensor_select <= 1'b0;
            sample_b_active <= 1'b0;
            result_write <= 1'b0;
            result_data <= {`ADCTS_RES_W{1'b0}};
        end else begin
            sts_reg <= sts_next;
            irq <= |(sts_next & msk_reg);
            scan_enable <= scr_reg[`ADCTS_SCAN_EN]; // [R1]
            charge_unit_enable <= scr_reg[`ADCTS_CU_REQ] && adc_active; // [R3]
            bandgap_enable <= scr_reg[`ADCTS_BG_REQ] && adc_active; // [R4]
            pos_select <= pos_cur; // [R16] [R19]
            neg_select <= neg_cur;
            // temperature path needs no per-channel charge enable
            temp_sensor_select <= temp_sel; // [R15]
            // low power only entered when enabled, left at next scan start
            if (scan_start || !scr_reg[`ADCTS_LP_EN]) begin
                low_power <= 1'b0; // [R2]
            end else if (scan_done) begin
                low_power <= 1'b1; // [R2]
            end
            if (scan_done || scan_start) begin
                match_seen_reg <= 1'b0;
            end else if (match_ev) begin
                match_seen_reg <= 1'b1;
            end
            if (!alt_reg) begin
                sample_b_active <= 1'b0; // [R19]
            end else if (conv_done) begin
                sample_b_active <= !sample_b_active; // [R19]
            end
            result_write <= store; // [R6] [R7] [R8]
            if (store) begin
                res_reg <= conv_result;
                result_data <= conv_result;
            end
        end
    end

endmodule

/* verilog/adcts_regs.vh */
// register map, field positions and reset values of the converter control
// assumes a 32-bit axi4-lite word bus, one register per aligned word
`ifndef ADCTS_REGS_VH
`define ADCTS_REGS_VH

`define ADCTS_RES_W 12

`define ADCTS_OFF_SCR 8'h00
`define ADCTS_OFF_ICS 8'h04
`define ADCTS_OFF_STS 8'h08
`define ADCTS_OFF_MSK 8'h0C
`define ADCTS_OFF_CTL 8'h10
`define ADCTS_OFF_LO 8'h14
`define ADCTS_OFF_HI 8'h18
`define ADCTS_OFF_RES 8'h1C

`define ADCTS_SCR_MASK 16'hF30F
`define ADCTS_SCR_RST 16'h0000
`define ADCTS_ICS_RST 16'h0000
`define ADCTS_LO_RST 12'h000
`define ADCTS_HI_RST 12'hFFF

`define ADCTS_SCAN_EN 15
`define ADCTS_LP_EN 14
`define ADCTS_CU_REQ 13
`define ADCTS_BG_REQ 12
`define ADCTS_IRQM_HI 9
`define ADCTS_IRQM_LO 8
`define ADCTS_WM_HI 3
`define ADCTS_WM_LO 2
`define ADCTS_CM_HI 1
`define ADCTS_CM_LO 0

`define ADCTS_WM_LEGACY 2'b00
`define ADCTS_WM_SAVE_MATCH 2'b01
`define ADCTS_WM_COMPARE 2'b10

`define ADCTS_CM_LT 2'b00
`define ADCTS_CM_GT 2'b01
`define ADCTS_CM_IN 2'b10
`define ADCTS_CM_OUT 2'b11

`define ADCTS_IRQM_NONE 2'b00
`define ADCTS_IRQM_SEQ 2'b01
`define ADCTS_IRQM_MATCH 2'b10
`define ADCTS_IRQM_BOTH 2'b11

`define ADCTS_EV_SCAN 0
`define ADCTS_EV_STORE 1
`define ADCTS_EV_BADCH 2

`define ADCTS_POS_AN9 5'h09
`define ADCTS_POS_AN12 5'h0C
`define ADCTS_POS_TEMP 5'h0D
`define ADCTS_POS_CHARGE 5'h0E
`define ADCTS_POS_REF_LO 5'h1B
`define ADCTS_NEG_REF 3'h0
`define ADCTS_NEG_AN1 3'h2

`define ADCTS_RESP_OKAY 2'b00
`define ADCTS_RESP_SLVERR 2'b10

`endif
